// ==== logic/xcs_pkg.sv ====
`default_nettype none
package xcs_pkg;
  localparam int unsigned ADDR_W           = 8;
  localparam int unsigned DATA_W           = 8;
  localparam int unsigned NUM_CONS         = 8;
  localparam int unsigned NUM_PERIPH       = 7;
  localparam int unsigned CNT_W            = 4;
  localparam int unsigned LOAD_W           = 2;

  // Clock control register
  localparam logic [7:0]  CTRL_ADDR        = 8'h8F;
  localparam logic [7:0]  CTRL_RESET       = 8'h00;
  localparam logic [7:0]  RDATA_UNMAPPED   = 8'h00;
  localparam int unsigned BIT_DOUBLE_SPEED = 0;
  localparam int unsigned BIT_TIMER0_OVR   = 1;
  localparam int unsigned BIT_TIMER1_OVR   = 2;
  localparam int unsigned BIT_TIMER2_OVR   = 3;
  localparam int unsigned BIT_SERIAL_OVR   = 4;
  localparam int unsigned BIT_COUNTER_OVR  = 5;
  localparam int unsigned BIT_WATCHDOG_OVR = 6;
  localparam int unsigned BIT_BUSCTL_OVR   = 7;

  // Crystal periods per machine or peripheral cycle
  localparam int unsigned STD_PERIODS      = 12;
  localparam int unsigned FAST_PERIODS     = 6;
  localparam logic [3:0]  CNT_LAST         = 4'hB;
  localparam logic [3:0]  CNT_FAST_MID     = 4'h5;
  localparam logic [3:0]  CNT_RESET        = 4'h0;
  localparam logic [1:0]  LOAD_DONE_CNT    = 2'h3;
endpackage : xcs_pkg
`default_nettype wire

// ==== logic/xcs_cycle_gen.sv ====
`timescale 1ns/1ns
`default_nettype none
module xcs_cycle_gen
  import xcs_pkg::*;
(
  input  wire logic                     clk,       // Crystal clock
  input  wire logic                     rst_n,     // Async reset, active low
  input  wire logic [xcs_pkg::CNT_W-1:0] phase_cnt, // Shared crystal period count
  input  wire logic                     fast_req,  // Requested double speed
  output logic                          fast_mode, // Effective double speed
  output logic                          cycle_tick // One pulse per cycle
);
  typedef struct packed {
    logic fast;
    logic tick;
  } xcs_gen_s;

  xcs_gen_s st_reg;
  xcs_gen_s st_next;

  function automatic logic xcs_tick_due(input logic [CNT_W-1:0] cnt, input logic fast);
    xcs_tick_due = (cnt == CNT_LAST) || (fast && (cnt == CNT_FAST_MID));
  endfunction : xcs_tick_due

  always_comb
  begin
    st_next      = st_reg;
    st_next.tick = xcs_tick_due(phase_cnt, st_reg.fast);
    // Mode taken only at the rising edge of the halved crystal clock
    if (phase_cnt[0] == 1'b0)
    begin
      st_next.fast = fast_req;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign fast_mode  = st_reg.fast;
  assign cycle_tick = st_reg.tick;
endmodule : xcs_cycle_gen
`default_nettype wire

// ==== logic/xcs_clock_ctrl.sv ====
`timescale 1ns/1ns
`default_nettype none
module xcs_clock_ctrl
  import xcs_pkg::*;
(
  input  wire logic                         clk,                  // Crystal input clock
  input  wire logic                         rst_n,                // Async reset, active low
  input  wire logic                         boot_fast_clock_fuse, // Nonvolatile boot fuse
  input  wire logic [xcs_pkg::ADDR_W-1:0]   sfr_addr,             // Register address
  input  wire logic                         sfr_wr,               // Write strobe
  input  wire logic                         sfr_rd,               // Read strobe
  input  wire logic [xcs_pkg::DATA_W-1:0]   sfr_wdata,            // Write data
  output logic      [xcs_pkg::DATA_W-1:0]   sfr_rdata,            // Read data, next cycle
  output logic                              crystal_half_clock,   // Crystal divided by two
  output logic                              cpu_cycle_tick,       // CPU machine cycle pulse
  output logic                              cpu_fast_mode,        // CPU in double speed
  output logic      [xcs_pkg::NUM_PERIPH-1:0] periph_cycle_tick,  // Peripheral cycle pulses
  output logic      [xcs_pkg::NUM_PERIPH-1:0] periph_fast_mode    // Peripherals in double speed
);
  typedef struct packed {
    logic [CNT_W-1:0]  cnt;
    logic              half;
    logic [DATA_W-1:0] ctl;
    logic [DATA_W-1:0] rdata;
    logic              fuse_s1;
    logic              fuse_s2;
    logic              fuse_s3;
    logic [LOAD_W-1:0] load_cnt;
    logic              load_done;
  } xcs_ctrl_s;

  xcs_ctrl_s st_reg;
  xcs_ctrl_s st_next;

  logic                ctl_hit;
  logic                fuse_load;
  logic [NUM_CONS-1:0] fast_req;
  logic [NUM_CONS-1:0] fast_eff;
  logic [NUM_CONS-1:0] tick_vec;

  function automatic logic [CNT_W-1:0] xcs_cnt_step(input logic [CNT_W-1:0] cnt);
    xcs_cnt_step = (cnt == CNT_LAST) ? CNT_RESET : cnt + 4'h1;
  endfunction : xcs_cnt_step

  assign ctl_hit   = (sfr_addr == CTRL_ADDR);
  assign fuse_load = !st_reg.load_done && (st_reg.load_cnt == LOAD_DONE_CNT) &&
                     (st_reg.fuse_s2 == st_reg.fuse_s3);

  // Consumer 0 is the CPU, consumer i is the peripheral at register bit i
  always_comb
  begin
    fast_req                   = '0;
    fast_req[BIT_DOUBLE_SPEED] = st_reg.ctl[BIT_DOUBLE_SPEED];
    for (int i = 1; i < NUM_CONS; i++)
    begin
      fast_req[i] = st_reg.ctl[BIT_DOUBLE_SPEED] && !st_reg.ctl[i];
    end
  end

  always_comb
  begin
    st_next         = st_reg;
    st_next.cnt     = xcs_cnt_step(st_reg.cnt);
    st_next.half    = !st_reg.half;
    st_next.fuse_s1 = boot_fast_clock_fuse;
    st_next.fuse_s2 = st_reg.fuse_s1;
    st_next.fuse_s3 = st_reg.fuse_s2;
    if (!st_reg.load_done && (st_reg.load_cnt != LOAD_DONE_CNT))
    begin
      st_next.load_cnt = st_reg.load_cnt + 2'h1;
    end
    if (fuse_load)
    begin
      st_next.load_done = 1'b1;
      if (st_reg.fuse_s3)
      begin
        st_next.ctl[BIT_DOUBLE_SPEED] = 1'b1;
      end
    end
    if (sfr_wr && ctl_hit)
    begin
      st_next.ctl = sfr_wdata;
    end
    st_next.rdata = st_reg.rdata;
    if (sfr_rd)
    begin
      st_next.rdata = ctl_hit ? st_reg.ctl : RDATA_UNMAPPED;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_reg       <= '0;
      st_reg.ctl   <= CTRL_RESET;
      st_reg.cnt   <= CNT_RESET;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  for (genvar g = 0; g < NUM_CONS; g++)
  begin : gen_cons
    xcs_cycle_gen u_gen (
      .clk        (clk),
      .rst_n      (rst_n),
      .phase_cnt  (st_reg.cnt),
      .fast_req   (fast_req[g]),
      .fast_mode  (fast_eff[g]),
      .cycle_tick (tick_vec[g])
    );
  end

  assign sfr_rdata          = st_reg.rdata;
  assign crystal_half_clock = st_reg.half;
  assign cpu_cycle_tick     = tick_vec[BIT_DOUBLE_SPEED];
  assign cpu_fast_mode      = fast_eff[BIT_DOUBLE_SPEED];
  assign periph_cycle_tick  = tick_vec[NUM_CONS-1:1];
  assign periph_fast_mode   = fast_eff[NUM_CONS-1:1];

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  fast_tick_a: assert property (
    cpu_fast_mode && (st_reg.cnt == CNT_FAST_MID) |=> cpu_cycle_tick)
    else $error("double speed CPU missed mid-cycle tick");

  half_div_a: assert property (
    $past(rst_n) |-> (crystal_half_clock != $past(crystal_half_clock)))
    else $error("halved clock did not toggle");

  std_tick_a: assert property (
    !cpu_fast_mode && (st_reg.cnt == CNT_FAST_MID) |=> !cpu_cycle_tick)
    else $error("standard mode CPU ticked at six periods");

  fuse_boot_a: assert property (
    fuse_load && st_reg.fuse_s3 && !sfr_wr |=> st_reg.ctl[BIT_DOUBLE_SPEED])
    else $error("boot fuse did not select double speed");

  ctl_write_a: assert property (
    sfr_wr && ctl_hit |=> (st_reg.ctl == $past(sfr_wdata)))
    else $error("clock control write not stored");

  cpu_only_a: assert property (
    (st_reg.ctl == 8'hFF) [*3] |-> (cpu_fast_mode && (periph_fast_mode == 7'h00)))
    else $error("mode bit alone changed peripheral speed");

  override_a: assert property (
    (st_reg.ctl[BIT_DOUBLE_SPEED] && !st_reg.ctl[BIT_TIMER0_OVR]) [*3] |-> periph_fast_mode[0])
    else $error("timer 0 not in double speed with override cleared");

  edge_sample_a: assert property (
    $changed(cpu_fast_mode) |-> ($past(st_reg.cnt[0]) == 1'b0))
    else $error("mode changed away from halved clock rising edge");

  periph_rate_a: assert property (
    periph_fast_mode[0] && (st_reg.cnt == CNT_FAST_MID) |=> periph_cycle_tick[0])
    else $error("double speed timer 0 missed mid-cycle tick");

  periph_std_a: assert property (
    !periph_fast_mode[0] && (st_reg.cnt == CNT_FAST_MID) |=> !periph_cycle_tick[0])
    else $error("standard timer 0 ticked at six periods");

  override_low_a: assert property (
    (!st_reg.ctl[BIT_DOUBLE_SPEED]) [*3] |-> (periph_fast_mode == 7'h00))
    else $error("peripheral doubled while mode bit low");

  read_back_a: assert property (
    sfr_rd && ctl_hit |=> (sfr_rdata == $past(st_reg.ctl)))
    else $error("clock control read mismatch");

  // Counter, divider, register, CPU tick, peripheral rate and timer 1/2, serial and bus controller override upkeep
  reset_std_a: assert property (
    !$past(rst_n) |-> ((st_reg.ctl == CTRL_RESET) && !cpu_fast_mode))
    else $error("clock control not at reset value after reset");

  cnt_range_a: assert property (
    st_reg.cnt <= CNT_LAST)
    else $error("crystal period counter out of range");

  half_phase_a: assert property (
    crystal_half_clock == st_reg.cnt[0])
    else $error("halved clock out of phase with period counter");

  last_tick_a: assert property (
    (st_reg.cnt == CNT_LAST) |=> cpu_cycle_tick)
    else $error("CPU missed end of cycle tick");

  idle_tick_a: assert property (
    (st_reg.cnt != CNT_LAST) && (st_reg.cnt != CNT_FAST_MID) |=> !cpu_cycle_tick)
    else $error("CPU ticked outside a cycle boundary");

  fuse_clear_a: assert property (
    fuse_load && !st_reg.fuse_s3 && !sfr_wr |=> (st_reg.ctl == $past(st_reg.ctl)))
    else $error("blank boot fuse changed clock control");

  ctl_hold_a: assert property (
    !(sfr_wr && ctl_hit) && !fuse_load |=> $stable(st_reg.ctl))
    else $error("clock control changed without a write");

  read_unmapped_a: assert property (
    sfr_rd && !ctl_hit |=> (sfr_rdata == RDATA_UNMAPPED))
    else $error("unmapped read returned data");

  rdata_hold_a: assert property (
    !sfr_rd |=> $stable(sfr_rdata))
    else $error("read data changed without a read");

  cpu_std_a: assert property (
    (!st_reg.ctl[BIT_DOUBLE_SPEED]) [*3] |-> !cpu_fast_mode)
    else $error("CPU in double speed with mode bit low");

  timer1_fast_a: assert property (
    periph_fast_mode[BIT_TIMER1_OVR-1] && (st_reg.cnt == CNT_FAST_MID)
    |=> periph_cycle_tick[BIT_TIMER1_OVR-1])
    else $error("double speed timer 1 missed mid-cycle tick");

  timer2_fast_a: assert property (
    periph_fast_mode[BIT_TIMER2_OVR-1] && (st_reg.cnt == CNT_FAST_MID)
    |=> periph_cycle_tick[BIT_TIMER2_OVR-1])
    else $error("double speed timer 2 missed mid-cycle tick");

  serial_fast_a: assert property (
    periph_fast_mode[BIT_SERIAL_OVR-1] && (st_reg.cnt == CNT_FAST_MID)
    |=> periph_cycle_tick[BIT_SERIAL_OVR-1])
    else $error("double speed serial port missed mid-cycle tick");

  counter_fast_a: assert property (
    periph_fast_mode[BIT_COUNTER_OVR-1] && (st_reg.cnt == CNT_FAST_MID)
    |=> periph_cycle_tick[BIT_COUNTER_OVR-1])
    else $error("double speed counter array missed mid-cycle tick");

  watchdog_fast_a: assert property (
    periph_fast_mode[BIT_WATCHDOG_OVR-1] && (st_reg.cnt == CNT_FAST_MID)
    |=> periph_cycle_tick[BIT_WATCHDOG_OVR-1])
    else $error("double speed watchdog missed mid-cycle tick");

  busctl_fast_a: assert property (
    periph_fast_mode[BIT_BUSCTL_OVR-1] && (st_reg.cnt == CNT_FAST_MID)
    |=> periph_cycle_tick[BIT_BUSCTL_OVR-1])
    else $error("double speed bus controller missed mid-cycle tick");

  timer1_std_a: assert property (
    !periph_fast_mode[BIT_TIMER1_OVR-1] && (st_reg.cnt == CNT_FAST_MID)
    |=> !periph_cycle_tick[BIT_TIMER1_OVR-1])
    else $error("standard timer 1 ticked at six periods");

  timer2_std_a: assert property (
    !periph_fast_mode[BIT_TIMER2_OVR-1] && (st_reg.cnt == CNT_FAST_MID)
    |=> !periph_cycle_tick[BIT_TIMER2_OVR-1])
    else $error("standard timer 2 ticked at six periods");

  serial_std_a: assert property (
    !periph_fast_mode[BIT_SERIAL_OVR-1] && (st_reg.cnt == CNT_FAST_MID)
    |=> !periph_cycle_tick[BIT_SERIAL_OVR-1])
    else $error("standard serial port ticked at six periods");

  counter_std_a: assert property (
    !periph_fast_mode[BIT_COUNTER_OVR-1] && (st_reg.cnt == CNT_FAST_MID)
    |=> !periph_cycle_tick[BIT_COUNTER_OVR-1])
    else $error("standard counter array ticked at six periods");

  watchdog_std_a: assert property (
    !periph_fast_mode[BIT_WATCHDOG_OVR-1] && (st_reg.cnt == CNT_FAST_MID)
    |=> !periph_cycle_tick[BIT_WATCHDOG_OVR-1])
    else $error("standard watchdog ticked at six periods");

  busctl_std_a: assert property (
    !periph_fast_mode[BIT_BUSCTL_OVR-1] && (st_reg.cnt == CNT_FAST_MID)
    |=> !periph_cycle_tick[BIT_BUSCTL_OVR-1])
    else $error("standard bus controller ticked at six periods");

  timer1_ovr_a: assert property (
    (st_reg.ctl[BIT_DOUBLE_SPEED] && !st_reg.ctl[BIT_TIMER1_OVR]) [*3]
    |-> periph_fast_mode[BIT_TIMER1_OVR-1])
    else $error("timer 1 not in double speed with override cleared");

  timer2_ovr_a: assert property (
    (st_reg.ctl[BIT_DOUBLE_SPEED] && !st_reg.ctl[BIT_TIMER2_OVR]) [*3]
    |-> periph_fast_mode[BIT_TIMER2_OVR-1])
    else $error("timer 2 not in double speed with override cleared");

  serial_ovr_a: assert property (
    (st_reg.ctl[BIT_DOUBLE_SPEED] && !st_reg.ctl[BIT_SERIAL_OVR]) [*3]
    |-> periph_fast_mode[BIT_SERIAL_OVR-1])
    else $error("serial port not in double speed with override cleared");

  busctl_ovr_a: assert property (
    (st_reg.ctl[BIT_DOUBLE_SPEED] && !st_reg.ctl[BIT_BUSCTL_OVR]) [*3]
    |-> periph_fast_mode[BIT_BUSCTL_OVR-1])
    else $error("bus controller not in double speed with override cleared");

  fast_run_c: cover property (cpu_fast_mode && cpu_cycle_tick);
  fuse_boot_c: cover property (fuse_load && st_reg.fuse_s3);
  mode_switch_c: cover property ($fell(cpu_fast_mode));
  mixed_c: cover property (cpu_fast_mode && !periph_fast_mode[0] && periph_fast_mode[6]);
  unmapped_rd_c: cover property (sfr_rd && !ctl_hit);
endmodule : xcs_clock_ctrl
`default_nettype wire

// ==== sim/xcs_cycle_sink.sv ====
`timescale 1ns/1ns
`default_nettype none
module xcs_cycle_sink
  import xcs_pkg::*;
(
  input  wire logic                         clk,   // Crystal clock
  input  wire logic                         rst_n, // Async reset, active low
  input  wire logic [xcs_pkg::NUM_CONS-1:0] tick,  // Cycle pulses, CPU in bit 0
  output logic [xcs_pkg::NUM_CONS-1:0][4:0] gap    // Clocks between the last two pulses
);
  import xcs_pkg::*;
  logic [NUM_CONS-1:0][4:0] run_reg;
  // Each consumer only sees its pulse train and measures its cycle length
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      run_reg <= '0;
      gap     <= '0;
    end
    else
    begin
      for (int i = 0; i < NUM_CONS; i++)
      begin
        if (tick[i])
        begin
          gap[i]     <= run_reg[i] + 5'h01;
          run_reg[i] <= 5'h00;
        end
        else if (run_reg[i] != 5'h1F)
          run_reg[i] <= run_reg[i] + 5'h01;
      end
    end
  end
endmodule : xcs_cycle_sink
`default_nettype wire

// ==== sim/test_x2_clock_mode_select.sv ====
`timescale 1ns/1ns
`default_nettype none
module test_x2_clock_mode_select;
  import xcs_pkg::*;
  logic                     clk       = 1'b0;
  logic                     rst_n     = 1'b0;
  logic                     fuse      = 1'b0;
  logic [ADDR_W-1:0]        sfr_addr  = 8'h00;
  logic                     sfr_wr    = 1'b0;
  logic                     sfr_rd    = 1'b0;
  logic [DATA_W-1:0]        sfr_wdata = 8'h00;
  logic [DATA_W-1:0]        sfr_rdata;
  logic                     half_clk;
  logic                     cpu_tick;
  logic                     cpu_fast;
  logic [NUM_PERIPH-1:0]    p_tick;
  logic [NUM_PERIPH-1:0]    p_fast;
  logic [NUM_CONS-1:0][4:0] gap;
  logic                     h;
  int                       n_fail     = 0;
  int                       num_checks = 0;
  int                       cycles     = 0;

  xcs_clock_ctrl i_dut (.clk(clk), .rst_n(rst_n), .boot_fast_clock_fuse(fuse),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .crystal_half_clock(half_clk), .cpu_cycle_tick(cpu_tick),
    .cpu_fast_mode(cpu_fast), .periph_cycle_tick(p_tick), .periph_fast_mode(p_fast));
  xcs_cycle_sink i_sink (.clk(clk), .rst_n(rst_n), .tick({p_tick, cpu_tick}), .gap(gap));

  initial forever #4 clk = ~clk;

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_fail++;
      test_done();
    end
  end

  task automatic test_done();
    $display("comparisons %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : test_done

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr_addr  <= a;
    sfr_wdata <= d;
    sfr_wr    <= 1'b1;
    @(posedge clk);
    sfr_wr <= 1'b0;
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    sfr_addr <= a;
    sfr_rd   <= 1'b1;
    @(posedge clk);
    sfr_rd <= 1'b0;
    @(posedge clk);
    #1 check(sfr_rdata, exp);
  endtask : rd_chk

  // Writes a control value, then checks adoption edge, flags and cycle lengths
  task automatic mode_chk(input logic [7:0] c);
    logic [6:0] pf;
    logic       old;
    pf  = c[0] ? ~c[7:1] : 7'h00;
    old = cpu_fast;
    wr(CTRL_ADDR, c);
    for (int k = 0; k < 4 && cpu_fast !== c[0]; k++)
      @(posedge clk) #1;
    if (old !== c[0])
      check(half_clk, 8'h01);
    repeat (40) @(posedge clk);
    #1 check(cpu_fast, c[0]);
    check(gap[0], c[0] ? 8'(FAST_PERIODS) : 8'(STD_PERIODS));
    check(p_fast, pf);
    for (int i = 0; i < NUM_PERIPH; i++)
      check(gap[i+1], pf[i] ? 8'(FAST_PERIODS) : 8'(STD_PERIODS));
    rd_chk(CTRL_ADDR, c);
  endtask : mode_chk

  initial
  begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (40) @(posedge clk);
    rd_chk(CTRL_ADDR, CTRL_RESET);
    #1 check(gap[0], 8'(STD_PERIODS));
    @(posedge clk) #1 h = half_clk;
    @(posedge clk) #1 check(half_clk, {7'h00, ~h});
    mode_chk(8'h01);
    mode_chk(8'hFF);
    mode_chk(8'hFE);
    mode_chk(8'h00);
    for (int i = 0; i < NUM_PERIPH; i++)
      mode_chk(8'hFF ^ (8'h02 << i));
    wr(8'h8E, 8'h55);
    rd_chk(CTRL_ADDR, 8'h7F);
    rd_chk(8'h8E, RDATA_UNMAPPED);
    @(posedge clk);
    rst_n <= 1'b0;
    fuse  <= 1'b1;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (40) @(posedge clk);
    #1 check(cpu_fast, 8'h01);
    check(gap[0], 8'(FAST_PERIODS));
    rd_chk(CTRL_ADDR, 8'h01);
    test_done();
  end
endmodule : test_x2_clock_mode_select
`default_nettype wire
